/* File: core/port_crossbar_map.svh */
/*
  Register offsets, field positions, reset values and pin counts for the
  port crossbar block. Assumes an 8-bit special register bus with a page
  number beside the address.
*/
`ifndef PORT_CROSSBAR_MAP_SVH
`define PORT_CROSSBAR_MAP_SVH

// -----------------------------------------------------------------------
// register offsets and page
// -----------------------------------------------------------------------
`define PXB_ADDR_PORT0_LATCH   8'h80
`define PXB_ADDR_PORT1_LATCH   8'h90
`define PXB_ADDR_PORT0_MODE    8'ha4
`define PXB_ADDR_PORT1_MODE    8'ha5
`define PXB_ADDR_PORT1_KIND    8'had
`define PXB_ADDR_ROUTE0        8'he1
`define PXB_ADDR_ROUTE1        8'he2
`define PXB_ADDR_ROUTE2        8'he3
`define PXB_ADDR_ROUTE3        8'he4
`define PXB_PAGE_CONFIG        8'h0f

// -----------------------------------------------------------------------
// reset values and write masks
// -----------------------------------------------------------------------
`define PXB_RST_LATCH          8'hff
`define PXB_RST_MODE           8'h00
`define PXB_RST_KIND           8'hff
`define PXB_RST_ROUTE          8'h00
`define PXB_ROUTE2_WMASK       8'hdf
`define PXB_ROUTE3_WMASK       8'h8f

// -----------------------------------------------------------------------
// field positions
// -----------------------------------------------------------------------
`define PXB_R0_TWO_WIRE        0
`define PXB_R0_FOUR_WIRE       1
`define PXB_R0_SERIAL_A        2
`define PXB_R0_CHAN_LO         3
`define PXB_R0_CHAN_HI         5
`define PXB_R0_COUNT_IN        6
`define PXB_R0_CMP_A           7
`define PXB_R2_CONV_A          0
`define PXB_R2_LOW_PORT        1
`define PXB_R2_SERIAL_B        2
`define PXB_R2_TMR_D           3
`define PXB_R2_TMR_D_CAP       4
`define PXB_R2_ROUTER_ON       6
`define PXB_R2_PULLUP_OFF      7
`define PXB_R3_TMR_C           0
`define PXB_R3_TMR_C_CAP       1
`define PXB_R3_CONV_B          2
`define PXB_R3_CMP_C           3
`define PXB_R3_CAN_DRIVE       7

// -----------------------------------------------------------------------
// pins
// -----------------------------------------------------------------------
`define PXB_PINS               16
`define PXB_STROBE_WR_PIN      7
`define PXB_STROBE_RD_PIN      6
`define PXB_STROBE_ALE_PIN     5

`endif

/* File: core/port_crossbar_pkg.sv */
/*
  Types for the port crossbar block. The signal enumeration order is the
  crossbar priority order: earlier signals take lower pins.
*/
package port_crossbar_pkg;

  typedef logic [7:0] sfr_byte_t;

  typedef enum {
    sig_serial_a_tx, sig_serial_a_rx,
    sig_spi_sck, sig_spi_miso, sig_spi_mosi, sig_spi_select,
    sig_twb_data, sig_twb_clk,
    sig_serial_b_tx, sig_serial_b_rx,
    sig_chan_0, sig_chan_1, sig_chan_2, sig_chan_3, sig_chan_4, sig_chan_5,
    sig_count_in, sig_cmp_a, sig_cmp_b, sig_cmp_c,
    sig_tmr_a0, sig_irq_a, sig_tmr_a1, sig_irq_b,
    sig_tmr_b, sig_tmr_b_cap, sig_tmr_c, sig_tmr_c_cap,
    sig_tmr_d, sig_tmr_d_cap, sig_sys_clk_n, sig_conv_a, sig_conv_b,
    sig_total
  } periph_sig_t;

  localparam int unsigned NSIG = sig_total;

endpackage

/* File: core/port_crossbar_config.sv */
/*
  Port crossbar: routing registers, port 0 / port 1 latches, drive modes and
  pin assignment. Assumes a single-cycle special register bus (address, page,
  byte and bit write strobes, read strobe) and peripherals that present one
  output value and drive request per routed signal.
*/
`timescale 1ns/1ps
`include "port_crossbar_map.svh"

// Overview of operation
// - two-wire bit routes data and clock pins
// - four-wire bit routes four pins, select optional
// - serial A takes pin 0 and 1
// - channel count n routes channels 0..n-1
// - comparator A and count input bits
// - register 1 bits route eight signals
// - global pullup disable bit
// - router off forces all pins input
// - bit 5 reads zero; timer D, serial B
// - converter A start input route bit
// - low-port claim multiplexed skips pins 7..5
// - non-multiplexed claim skips pins 7,6 only
// - CAN transmit open-drain or push-pull
// - reserved bits; comparator C, converter B, timer C
// - routing registers reset zero at e1..e4
// - latch drives pin; high floats open-drain
// - port read returns pin level
// - latches reset ones, bit-writable, every page
// - port 0 drive mode bits, reset zero
// - two-wire and mode-0 receive always open-drain
// - analog port 1 pins skipped, input off
// - memory interface drives address and strobes
// - analog pin reads zero, pullup off
module port_crossbar_config (
  // clock and reset
  input  wire logic                                    i_clock,
  input  wire logic                                    i_rst_n,
  // special register bus
  input  wire port_crossbar_pkg::sfr_byte_t            i_sfr_addr,
  input  wire port_crossbar_pkg::sfr_byte_t            i_sfr_page,
  input  wire logic                                    i_sfr_wr,
  input  wire port_crossbar_pkg::sfr_byte_t            i_sfr_wdata,
  input  wire logic                                    i_sfr_bit_wr,
  input  wire logic [2:0]                              i_sfr_bit_idx,
  input  wire logic                                    i_sfr_bit_val,
  input  wire logic                                    i_sfr_rd,
  output           port_crossbar_pkg::sfr_byte_t       o_sfr_rdata,
  // peripheral side
  input  wire logic [port_crossbar_pkg::NSIG-1:0]      i_periph_out,
  input  wire logic [port_crossbar_pkg::NSIG-1:0]      i_periph_drive,
  output logic     [port_crossbar_pkg::NSIG-1:0]       o_periph_in,
  input  wire logic                                    i_spi_three_wire,
  input  wire logic                                    i_serial_a_mode0,
  input  wire logic                                    i_serial_b_mode0,
  // memory interface
  input  wire logic                                    i_mem_if_nonmux,
  input  wire logic                                    i_mem_if_wr_n,
  input  wire logic                                    i_mem_if_rd_n,
  input  wire logic                                    i_mem_if_ale,
  input  wire logic                                    i_mem_if_addr_en,
  input  wire logic [7:0]                              i_mem_if_addr_hi,
  // CAN transmit
  input  wire logic                                    i_can_tx,
  output logic                                         o_can_tx_out,
  output logic                                         o_can_tx_oe,
  // port pins 0..7 = port 0, 8..15 = port 1
  input  wire logic [`PXB_PINS-1:0]                    i_pin_in,
  output logic     [`PXB_PINS-1:0]                     o_pin_out,
  output logic     [`PXB_PINS-1:0]                     o_pin_oe,
  output logic     [`PXB_PINS-1:0]                     o_pullup_en
);
  import port_crossbar_pkg::*;

  // -----------------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------------
  sfr_byte_t port0_latch_reg, port1_latch_reg;
  sfr_byte_t port0_mode_reg, port1_mode_reg, port1_kind_reg;
  sfr_byte_t route0_reg, route1_reg, route2_reg, route3_reg;

  // one decode helper used for every register hit
  function automatic logic sfr_hit(input sfr_byte_t addr, input sfr_byte_t page,
                                   input sfr_byte_t want, input logic any_page);
    sfr_hit = (addr == want) && (any_page || page == `PXB_PAGE_CONFIG);
  endfunction

  wire hit_p0   = sfr_hit(i_sfr_addr, i_sfr_page, `PXB_ADDR_PORT0_LATCH, 1'b1);
  wire hit_p1   = sfr_hit(i_sfr_addr, i_sfr_page, `PXB_ADDR_PORT1_LATCH, 1'b1);
  wire hit_m0   = sfr_hit(i_sfr_addr, i_sfr_page, `PXB_ADDR_PORT0_MODE, 1'b0);
  wire hit_m1   = sfr_hit(i_sfr_addr, i_sfr_page, `PXB_ADDR_PORT1_MODE, 1'b0);
  wire hit_k1   = sfr_hit(i_sfr_addr, i_sfr_page, `PXB_ADDR_PORT1_KIND, 1'b0);
  wire hit_r0   = sfr_hit(i_sfr_addr, i_sfr_page, `PXB_ADDR_ROUTE0, 1'b0);
  wire hit_r1   = sfr_hit(i_sfr_addr, i_sfr_page, `PXB_ADDR_ROUTE1, 1'b0);
  wire hit_r2   = sfr_hit(i_sfr_addr, i_sfr_page, `PXB_ADDR_ROUTE2, 1'b0);
  wire hit_r3   = sfr_hit(i_sfr_addr, i_sfr_page, `PXB_ADDR_ROUTE3, 1'b0);

  // bit writes touch only the latch bit, never the pin level
  wire [7:0] bit_onehot = 8'h01 << i_sfr_bit_idx;
  wire [7:0] bit_fill   = {8{i_sfr_bit_val}};
  wire [7:0] p0_bitwise = (port0_latch_reg & ~bit_onehot) | (bit_fill & bit_onehot);
  wire [7:0] p1_bitwise = (port1_latch_reg & ~bit_onehot) | (bit_fill & bit_onehot);

  // latches: byte write, else bit write
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      port0_latch_reg <= `PXB_RST_LATCH;
      port1_latch_reg <= `PXB_RST_LATCH;
    end else begin
      if (i_sfr_wr && hit_p0) port0_latch_reg <= i_sfr_wdata;
      else if (i_sfr_bit_wr && hit_p0) port0_latch_reg <= p0_bitwise;
      if (i_sfr_wr && hit_p1) port1_latch_reg <= i_sfr_wdata;
      else if (i_sfr_bit_wr && hit_p1) port1_latch_reg <= p1_bitwise;
    end
  end

  // configuration registers on the config page; unused bits never stored
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      port0_mode_reg <= `PXB_RST_MODE;
      port1_mode_reg <= `PXB_RST_MODE;
      port1_kind_reg <= `PXB_RST_KIND;
      route0_reg     <= `PXB_RST_ROUTE;
      route1_reg     <= `PXB_RST_ROUTE;
      route2_reg     <= `PXB_RST_ROUTE;
      route3_reg     <= `PXB_RST_ROUTE;
    end else if (i_sfr_wr) begin
      if (hit_m0) port0_mode_reg <= i_sfr_wdata;
      if (hit_m1) port1_mode_reg <= i_sfr_wdata;
      if (hit_k1) port1_kind_reg <= i_sfr_wdata;
      if (hit_r0) route0_reg     <= i_sfr_wdata;
      if (hit_r1) route1_reg     <= i_sfr_wdata;
      if (hit_r2) route2_reg     <= i_sfr_wdata & `PXB_ROUTE2_WMASK;
      if (hit_r3) route3_reg     <= i_sfr_wdata & `PXB_ROUTE3_WMASK;
    end
  end

  // -----------------------------------------------------------------------
  // routing enables and skipped pins
  // -----------------------------------------------------------------------
  wire       router_on      = route2_reg[`PXB_R2_ROUTER_ON];
  wire       pullup_off     = route2_reg[`PXB_R2_PULLUP_OFF];
  wire       low_port_claim = route2_reg[`PXB_R2_LOW_PORT];
  wire [2:0] chan_count     = route0_reg[`PXB_R0_CHAN_HI:`PXB_R0_CHAN_LO];
  wire       four_wire      = route0_reg[`PXB_R0_FOUR_WIRE];
  wire       serial_a       = route0_reg[`PXB_R0_SERIAL_A];
  wire       serial_b       = route2_reg[`PXB_R2_SERIAL_B];
  wire       two_wire       = route0_reg[`PXB_R0_TWO_WIRE];
  logic [NSIG-1:0] sig_en;

  // enable of each signal in priority order
  always_comb begin
    sig_en = '0;
    sig_en[sig_serial_a_tx] = serial_a;
    sig_en[sig_serial_a_rx] = serial_a;
    sig_en[sig_spi_sck]     = four_wire;
    sig_en[sig_spi_miso]    = four_wire;
    sig_en[sig_spi_mosi]    = four_wire;
    sig_en[sig_spi_select]  = four_wire && !i_spi_three_wire;
    sig_en[sig_twb_data]    = two_wire;
    sig_en[sig_twb_clk]     = two_wire;
    sig_en[sig_serial_b_tx] = serial_b;
    sig_en[sig_serial_b_rx] = serial_b;
    for (int c = 0; c < 6; c++) begin
      sig_en[int'(sig_chan_0) + c] = (c < int'(chan_count));
    end
    sig_en[sig_count_in]   = route0_reg[`PXB_R0_COUNT_IN];
    sig_en[sig_cmp_a]      = route0_reg[`PXB_R0_CMP_A];
    sig_en[sig_cmp_b]      = route1_reg[0];
    sig_en[sig_cmp_c]      = route3_reg[`PXB_R3_CMP_C];
    sig_en[sig_tmr_a0]     = route1_reg[1];
    sig_en[sig_irq_a]      = route1_reg[2];
    sig_en[sig_tmr_a1]     = route1_reg[3];
    sig_en[sig_irq_b]      = route1_reg[4];
    sig_en[sig_tmr_b]      = route1_reg[5];
    sig_en[sig_tmr_b_cap]  = route1_reg[6];
    sig_en[sig_tmr_c]      = route3_reg[`PXB_R3_TMR_C];
    sig_en[sig_tmr_c_cap]  = route3_reg[`PXB_R3_TMR_C_CAP];
    sig_en[sig_tmr_d]      = route2_reg[`PXB_R2_TMR_D];
    sig_en[sig_tmr_d_cap]  = route2_reg[`PXB_R2_TMR_D_CAP];
    sig_en[sig_sys_clk_n]  = route1_reg[7];
    sig_en[sig_conv_a]     = route2_reg[`PXB_R2_CONV_A];
    sig_en[sig_conv_b]     = route3_reg[`PXB_R3_CONV_B];
  end

  // strobe pins claimed by the memory interface, analog port 1 pins
  wire       claim_ale  = low_port_claim && !i_mem_if_nonmux;
  wire [7:0] p0_claim   = {low_port_claim, low_port_claim, claim_ale, 5'h00};
  wire [15:0] pin_skip  = {~port1_kind_reg, p0_claim};

  // -----------------------------------------------------------------------
  // priority packing: each enabled signal takes the next unskipped pin
  // -----------------------------------------------------------------------
  logic [`PXB_PINS-1:0] pin_used;
  logic [5:0]           pin_sig [`PXB_PINS];
  logic [NSIG-1:0]      sig_has_pin;
  logic [3:0]           sig_pin [NSIG];
  logic [4:0]           ptr;

  always_comb begin
    ptr         = '0;
    pin_used    = '0;
    sig_has_pin = '0;
    for (int p = 0; p < `PXB_PINS; p++) pin_sig[p] = '0;
    for (int s = 0; s < NSIG; s++) sig_pin[s] = '0;
    for (int s = 0; s < NSIG; s++) begin
      if (sig_en[s]) begin
        for (int j = 0; j < `PXB_PINS; j++) begin
          if (ptr < 5'd16 && pin_skip[ptr[3:0]]) ptr = ptr + 5'd1;
        end
        if (ptr < 5'd16) begin
          pin_used[ptr[3:0]] = 1'b1;
          pin_sig[ptr[3:0]]  = 6'(s);
          sig_has_pin[s]     = 1'b1;
          sig_pin[s]         = ptr[3:0];
          ptr                = ptr + 5'd1;
        end
      end
    end
  end

  // -----------------------------------------------------------------------
  // pin drive
  // -----------------------------------------------------------------------
  // strobes reach only claimed pins; an unclaimed port 0 pin follows its latch alone
  wire [7:0]  strobe_val = ~p0_claim | {i_mem_if_wr_n, i_mem_if_rd_n, i_mem_if_ale, 5'h1f};
  wire [7:0]  addr_val   = (i_mem_if_nonmux && i_mem_if_addr_en) ? i_mem_if_addr_hi
                                                                 : 8'hff;
  wire [15:0] latch_val  = {port1_latch_reg & addr_val, port0_latch_reg & strobe_val};
  wire [15:0] mode_bits  = {port1_mode_reg, port0_mode_reg};
  logic [15:0] pin_out_next, pin_oe_next, pin_od_next;

  // open-drain releases high; push-pull drives both levels
  always_comb begin
    logic v;
    logic drv;
    logic force_od;
    int   s;
    v            = 1'b1;
    drv          = 1'b0;
    force_od     = 1'b0;
    s            = 0;
    pin_out_next = '0;
    pin_oe_next  = '0;
    pin_od_next  = '0;
    for (int p = 0; p < `PXB_PINS; p++) begin
      s        = int'(pin_sig[p]);
      force_od = pin_used[p] && (s == sig_twb_data || s == sig_twb_clk ||
                 (s == sig_serial_a_rx && i_serial_a_mode0) ||
                 (s == sig_serial_b_rx && i_serial_b_mode0));
      v   = pin_used[p] ? i_periph_out[s] : latch_val[p];
      drv = pin_used[p] ? i_periph_drive[s] : 1'b1;
      pin_od_next[p]  = !mode_bits[p] || force_od;
      pin_oe_next[p]  = router_on && drv && (!pin_od_next[p] || !v);
      pin_out_next[p] = v && !pin_od_next[p];
    end
  end

  // analog port 1 pins read low; pullups off globally or on analog pins
  wire [15:0] pin_level   = i_pin_in & {port1_kind_reg, 8'hff};
  wire [15:0] pullup_next = pullup_off ? 16'h0000 : {port1_kind_reg, 8'hff};
  wire        can_oe_next = i_can_tx ? route3_reg[`PXB_R3_CAN_DRIVE] : 1'b1;
  logic [NSIG-1:0] periph_in_next;

  // unrouted inputs idle high so peripherals see no false edge
  always_comb begin
    for (int s = 0; s < NSIG; s++) begin
      periph_in_next[s] = sig_has_pin[s] ? pin_level[sig_pin[s]] : 1'b1;
    end
  end

  // read data is selected by address; unmapped addresses read zero
  sfr_byte_t rdata_next;
  always_comb begin
    rdata_next = '0;
    if (hit_p0) rdata_next = pin_level[7:0];
    if (hit_p1) rdata_next = pin_level[15:8];
    if (hit_m0) rdata_next = port0_mode_reg;
    if (hit_m1) rdata_next = port1_mode_reg;
    if (hit_k1) rdata_next = port1_kind_reg;
    if (hit_r0) rdata_next = route0_reg;
    if (hit_r1) rdata_next = route1_reg;
    if (hit_r2) rdata_next = route2_reg;
    if (hit_r3) rdata_next = route3_reg;
  end

  // every output leaves from a flop; pins lag the registers by one cycle
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_pin_out    <= '0;
      o_pin_oe     <= '0;
      o_pullup_en  <= '0;
      o_periph_in  <= '1;
      o_sfr_rdata  <= '0;
      o_can_tx_out <= 1'b0;
      o_can_tx_oe  <= 1'b0;
    end else begin
      o_pin_out    <= pin_out_next;
      o_pin_oe     <= pin_oe_next;
      o_pullup_en  <= pullup_next;
      o_periph_in  <= periph_in_next;
      o_can_tx_out <= i_can_tx && route3_reg[`PXB_R3_CAN_DRIVE];
      o_can_tx_oe  <= can_oe_next;
      if (i_sfr_rd) o_sfr_rdata <= rdata_next;
    end
  end

  // -----------------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------------
  logic [15:0] od_seen_reg;
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) od_seen_reg <= '1;
    else od_seen_reg <= pin_od_next;
  end

  sequence cfg_read(sfr_byte_t a);
    i_sfr_rd && i_sfr_addr == a && i_sfr_page == `PXB_PAGE_CONFIG;
  endsequence

  route_reset_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !$past(i_rst_n) |-> (route0_reg | route1_reg | route2_reg | route3_reg) == 8'h00)
    else $error("routing registers not zero after reset");
  latch_reset_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !$past(i_rst_n) |-> port0_latch_reg == 8'hff && port1_latch_reg == 8'hff)
    else $error("port latches not all ones after reset");
  router_off_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !router_on |=> o_pin_oe == 16'h0000)
    else $error("pin driven while router disabled");
  unused_bit_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    cfg_read(`PXB_ADDR_ROUTE2) |=> !o_sfr_rdata[5])
    else $error("unused routing bit read as one");
  reserved_bits_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    cfg_read(`PXB_ADDR_ROUTE3) |=> o_sfr_rdata[6:4] == 3'h0)
    else $error("reserved routing bits read as nonzero");
  pin_read_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_sfr_rd && i_sfr_addr == `PXB_ADDR_PORT0_LATCH |=> o_sfr_rdata == $past(i_pin_in[7:0]))
    else $error("port read did not return pin level");
  analog_read_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_sfr_rd && i_sfr_addr == `PXB_ADDR_PORT1_LATCH && !port1_kind_reg[0]
    |=> !o_sfr_rdata[0] && !o_pullup_en[8])
    else $error("analog pin read high or kept its pullup");
  serial_a_pin_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    router_on && serial_a && port0_mode_reg[0] && i_periph_drive[sig_serial_a_tx]
    |=> o_pin_oe[0] && o_pin_out[0] == $past(i_periph_out[sig_serial_a_tx]))
    else $error("serial A transmit not on pin 0");
  open_drain_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (o_pin_oe & o_pin_out & od_seen_reg) == 16'h0000)
    else $error("open-drain pin driven high");
  can_drive_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !route3_reg[`PXB_R3_CAN_DRIVE] |=> !(o_can_tx_oe && o_can_tx_out))
    else $error("CAN transmit driven high in open-drain");
  strobe_skip_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    router_on && low_port_claim && port0_mode_reg[7]
    |=> o_pin_out[7] == ($past(port0_latch_reg[7]) && $past(i_mem_if_wr_n)))
    else $error("claimed strobe pin not driven by latch and memory interface");

endmodule

/* File: tb/pin_model.sv */
/* pin model: resolves port pin levels from device drive.
   Assumes released pins without pullup follow the board level i_ext. */
`timescale 1ns/1ps
module pin_model (
  // device side
  input  wire logic [15:0] i_out,
  input  wire logic [15:0] i_oe,
  input  wire logic [15:0] i_pull,
  // board side
  input  wire logic [15:0] i_ext,
  output logic      [15:0] o_pin
);
  // driven pins win; the bench sets ext to one random value once and then holds it
  assign o_pin = (i_oe & i_out) | (~i_oe & (i_pull | i_ext));
endmodule

/* File: tb/tb_top.sv */
/* tb_top: self-checking bench for the port crossbar.
   Assumes pin_model closes the loop from pin drive to pin level. */
`timescale 1ns/1ps
`include "port_crossbar_map.svh"
module tb_top;
  import port_crossbar_pkg::*;
  logic clk = 0, rst_n = 0, wr = 0, bwr = 0, bval = 0, rd = 0, nmux = 0;
  logic wrn = 1, rdn = 1, ale = 0, can = 0, tw = 0, sm0 = 0, aen = 0;
  logic [2:0] bidx = 0, s;
  logic [7:0] addr = 0, page = 0, wd = 0, v, rdata, ahi = 0;
  logic [NSIG-1:0] pout = '0, pdrv = '0, pin_of;
  logic [15:0] ext = '0, pin, pout_w, oe, pu;
  logic can_transmit_pin, ctx_oe;
  int bad_count = 0, cmp_count = 0;
  port_crossbar_config u_port_crossbar_config (.i_clock(clk), .i_rst_n(rst_n),
    .i_sfr_addr(addr), .i_sfr_page(page), .i_sfr_wr(wr), .i_sfr_wdata(wd),
    .i_sfr_bit_wr(bwr), .i_sfr_bit_idx(bidx), .i_sfr_bit_val(bval), .i_sfr_rd(rd),
    .o_sfr_rdata(rdata), .i_periph_out(pout), .i_periph_drive(pdrv),
    .o_periph_in(pin_of), .i_spi_three_wire(tw), .i_serial_a_mode0(sm0),
    .i_serial_b_mode0(sm0), .i_mem_if_nonmux(nmux), .i_mem_if_wr_n(wrn),
    .i_mem_if_rd_n(rdn), .i_mem_if_ale(ale), .i_mem_if_addr_en(aen),
    .i_mem_if_addr_hi(ahi), .i_can_tx(can), .o_can_tx_out(can_transmit_pin),
    .o_can_tx_oe(ctx_oe), .i_pin_in(pin), .o_pin_out(pout_w), .o_pin_oe(oe),
    .o_pullup_en(pu));
  pin_model u_pin_model (.i_out(pout_w), .i_oe(oe), .i_pull(pu), .i_ext(ext), .o_pin(pin));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] chan_mask(int n);
    return 8'((1 << n) - 1);
  endfunction
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrr(logic [7:0] a, logic [7:0] d, logic [7:0] pg = 8'h0f);
    @(posedge clk);
    addr <= a;
    page <= pg;
    wd <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  // read data is looked at two extra edges late; it holds until the next read
  task automatic rdc(string nm, logic [7:0] a, logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    page <= 8'h0f;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    repeat (2) @(posedge clk);
    #1 chk(nm, rdata, exp);
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------------------------------
  initial begin
    forever #2.5 clk = ~clk;
  end
  // the tests need a few hundred cycles; 50000 leaves ample margin
  initial begin
    #250000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    void'($urandom(38144));
    repeat (8) @(posedge clk);
    rst_n <= 1;
    rdc("route0", `PXB_ADDR_ROUTE0, 8'h00);
    rdc("mode0", `PXB_ADDR_PORT0_MODE, 8'h00);
    rdc("port0 pulled", `PXB_ADDR_PORT0_LATCH, 8'hff);
    chk("pullups", pu, 16'hffff);
    wrr(`PXB_ADDR_PORT0_LATCH, 8'h00);
    settle();
    chk("router off", oe, 16'h0000);
    wrr(`PXB_ADDR_ROUTE2, 8'hff);
    rdc("route2 mask", `PXB_ADDR_ROUTE2, 8'hdf);
    chk("pullups off", pu, 16'h0000);
    wrr(`PXB_ADDR_ROUTE3, 8'hff);
    rdc("route3 mask", `PXB_ADDR_ROUTE3, 8'h8f);
    wrr(`PXB_ADDR_ROUTE1, 8'h55, 8'h00);
    rdc("wrong page", `PXB_ADDR_ROUTE1, 8'h00);
    rdc("unmapped", 8'h00, 8'h00);
    repeat (4) begin
      v = 8'($urandom);
      wrr(`PXB_ADDR_ROUTE1, v);
      rdc("route1", `PXB_ADDR_ROUTE1, v);
    end
    wrr(`PXB_ADDR_ROUTE1, 8'h00);
    wrr(`PXB_ADDR_ROUTE3, 8'h00);
    wrr(`PXB_ADDR_ROUTE2, 8'hc0);
    settle();
    chk("latch low od", {oe, pout_w[7:0]}, 24'h00ff00);
    @(posedge clk);
    addr <= `PXB_ADDR_PORT0_LATCH;
    bidx <= 3'h0;
    bval <= 1;
    bwr <= 1;
    @(posedge clk);
    bwr <= 0;
    settle();
    chk("high floats", oe, 16'h00fe);
    wrr(`PXB_ADDR_PORT0_MODE, 8'hff);
    ext <= 16'($urandom);
    settle();
    chk("push pull", {oe[7:0], pout_w[7:0]}, 16'hff01);
    rdc("port1 pins", `PXB_ADDR_PORT1_LATCH, ext[15:8]);
    v = 8'($urandom);
    wrr(`PXB_ADDR_ROUTE0, 8'h04);
    pout <= NSIG'(v[0]);
    pdrv <= NSIG'(1);
    settle();
    chk("serial a", {oe[0], pout_w[0], pin_of[1]}, {1'b1, v[0], ext[1]});
    wrr(`PXB_ADDR_ROUTE0, 8'h01);
    pout <= NSIG'(64'h40);
    pdrv <= NSIG'(64'h40);
    settle();
    chk("two wire", {oe[0], pin_of[7]}, {1'b0, ext[1]});
    wrr(`PXB_ADDR_PORT0_LATCH, 8'hff);
    pout <= '0;
    pdrv <= NSIG'(64'hfc00);
    for (int n = 0; n < 7; n++) begin
      wrr(`PXB_ADDR_ROUTE0, 8'(n << 3));
      settle();
      chk("channels", pout_w[7:0], 8'(~chan_mask(n)));
    end
    for (int m = 0; m < 2; m++) begin
      s = 3'($urandom);
      wrr(`PXB_ADDR_ROUTE2, 8'hc2);
      {wrn, rdn, ale} <= s;
      nmux <= m[0];
      settle();
      chk("strobes", pout_w[7:5], {s[2:1], s[0] && !m[0]});
      chk("chan5 skip", oe[8], !m[0]);
    end
    // serial A and four-wire bus on pins 0..5; receive high, all else low
    wrr(`PXB_ADDR_ROUTE0, 8'h06);
    pout <= NSIG'(2);
    pdrv <= '1;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      {tw, sm0} <= 2'(k);
      aen <= k[0];
      ahi <= 8'($urandom);
      settle();
      chk("rx mode0 od", oe[1], !sm0);
      chk("spi select", pout_w[5], tw);
      chk("upper addr", oe[15:8], aen ? 8'(~ahi) : 8'h00);
    end
    @(posedge clk);
    can <= 1;
    settle();
    chk("can od", ctx_oe, 1'b0);
    wrr(`PXB_ADDR_ROUTE3, 8'h80);
    settle();
    chk("can pp", {ctx_oe, can_transmit_pin}, 2'b11);
    wrr(`PXB_ADDR_PORT1_KIND, 8'h00);
    rdc("analog", `PXB_ADDR_PORT1_LATCH, 8'h00);
    report_and_stop();
  end
endmodule
